//--- design/tpiu_pkg.sv
// Constants and state types for the timer, pulse and interrupt unit
// What this block does
// RQ1 - Three 8-bit up counters, each with its own count and reload latch.
// RQ2 - Run bit stops or starts a timer; duty_timer_a run also gates pulse_channel_a.
// RQ3 - With autoload set, a latch write also loads the counter.
// RQ4 - Autoload change acts only from the next latch write onward.
// RQ5 - On wrap the counter reloads from its latch.
// RQ6 - Clock source 00 pin, 01 oscillator, 10 internal RC, 11 reserved.
// RQ7 - Edge select applies to the pin: 0 rising, 1 falling.
// RQ8 - Prescaler divides the selected clock by two to the field value.
// RQ9 - Pair mode joins period_timer_b and duty_timer_d into pulse_channel_b.
// RQ10 - pulse_channel_b initial level: 0 starts high, 1 starts low; duty overflow flips.
// RQ11 - pulse_channel_b event raised after rate field plus one pulses.
// RQ12 - Global enable off blocks all interrupts; on passes enabled sources.
// RQ13 - An enabled event taken clears the global enable by hardware.
// RQ14 - Return from interrupt sets the global enable again.
// RQ15 - Mask bits 6..0: ADC, port A, timer d, timer b, timer a, first, wide.
// RQ16 - Flag register bit 7 always reads zero.
// RQ17 - Timer flags set on overflow, stay until software clears them.
// RQ18 - Shared b flag set on period overflow outside pair mode, on reaching pulse rate in pair mode.
// RQ19 - Port A flag set on change of any enabled port A pin.
// RQ20 - ADC flag set on end of conversion, held until software clears.
// RQ21 - pulse_channel_a initial level: 0 starts high, 1 starts low; duty_timer_a overflow flips.
// RQ22 - Interrupt request when global enable and any flag with its enable are set.
// RQ23 - Each period overflow in pulse mode restores the level and restarts the duty timer; on pulse_channel_a the code does not restart duty_timer_a.
package tpiu_pkg;

  // ************************************************
  // Register indices; byte address is four times the index
  // ************************************************
  localparam logic [7:0] IDX_PA_CTL   = 8'h16;
  localparam logic [7:0] IDX_A_CTL    = 8'h19;
  localparam logic [7:0] IDX_A_LATCH  = 8'h1A;
  localparam logic [7:0] IDX_A_CNT    = 8'h1B;
  localparam logic [7:0] IDX_B_CTL    = 8'h1C;
  localparam logic [7:0] IDX_PB_CTL   = 8'h1D;
  localparam logic [7:0] IDX_B_LATCH  = 8'h1E;
  localparam logic [7:0] IDX_B_CNT    = 8'h1F;
  localparam logic [7:0] IDX_D_CTL    = 8'h20;
  localparam logic [7:0] IDX_D_LATCH  = 8'h21;
  localparam logic [7:0] IDX_D_CNT    = 8'h22;
  localparam logic [7:0] IDX_MASK     = 8'h25;
  localparam logic [7:0] IDX_FLAGS    = 8'h26;
  localparam logic [7:0] IDX_PA_EN    = 8'h3A;
  localparam int         IDX_LSB      = 2;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int CTL_RUN      = 7;
  localparam int CTL_AUTOLOAD = 6;
  localparam int CTL_SRC_LO   = 4;
  localparam int CTL_EDGE     = 3;
  localparam int PB_PAIR      = 7;
  localparam int PB_INIT      = 6;
  localparam int GIE_BIT      = 7;
  localparam int EV_ADC       = 6;
  localparam int EV_PORTA     = 5;
  localparam int EV_D         = 4;
  localparam int EV_B         = 3;
  localparam int EV_A         = 2;
  localparam int EV_FIRST     = 1;
  localparam int EV_WIDE      = 0;

  // ************************************************
  // Codes, timer slots and reset values
  // ************************************************
  localparam logic [1:0] SRC_PIN  = 2'h0;
  localparam logic [1:0] SRC_OSC  = 2'h1;
  localparam logic [1:0] SRC_IRC  = 2'h2;
  localparam int         T_A      = 0;
  localparam int         T_B      = 1;
  localparam int         T_D      = 2;
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [7:0] CNT_TOP  = 8'hFF;
  localparam logic [6:0] PRE_ALL  = 7'h7F;

  typedef struct packed {
    logic [2:0][7:0] ctl;
    logic [2:0][7:0] latch;
    logic [2:0][7:0] cnt;
    logic [2:0][6:0] pre;
    logic [7:0]      pb_ctl;
    logic [7:0]      pa_ctl;
    logic [7:0]      mask;
    logic [7:0]      flags;
    logic [7:0]      pa_en;
    logic [7:0]      pa_prev;
    logic [3:0]      pulses;
    logic            pin_prev;
    logic            out_a;
    logic            out_b;
    logic            irq;
    logic            ap_valid;
    logic            ap_write;
    logic [7:0]      ap_idx;
    logic [7:0]      rdata;
    logic            hready;
  } tpiu_state_t;

endpackage

//--- design/tpiu_top.sv
// Timer, pulse and interrupt unit with its AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tpiu_top import tpiu_pkg::*; (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer clock sources
  input  wire logic        external_timer_clock_pin,
  input  wire logic        osc_tick,
  input  wire logic        irc_tick,
  // Events from neighbouring blocks
  input  wire logic        first_timer_period,
  input  wire logic        first_timer_event,
  input  wire logic        wide_timer_event,
  input  wire logic        conversion_done,
  input  wire logic [7:0]  port_a_pins,
  input  wire logic        return_from_interrupt_op,
  // Outputs
  output logic             pulse_channel_a,
  output logic             pulse_channel_b,
  output logic             irq_req
);

  tpiu_state_t s_q;
  tpiu_state_t s_d;
  logic [2:0]  src_tick;
  logic [2:0]  cnt_tick;
  logic [2:0]  ovf;
  logic [6:0]  ev;
  logic        wr_en;
  logic [7:0]  wd;
  logic        hit;
  logic        pair_b;
  logic        rate_hit;
  logic        pin_edge_r;
  logic        pin_edge_f;

  // ************************************************
  // Register read decode
  // ************************************************
  function automatic logic [7:0] read_reg(input logic [7:0] idx, input tpiu_state_t s);
    logic [7:0] r;
    r = RST_REG;
    case (idx)
      IDX_PA_CTL:  r = {s.pa_ctl[7:6], 6'h00};
      IDX_A_CTL:   r = s.ctl[T_A];
      IDX_A_LATCH: r = s.latch[T_A];
      IDX_A_CNT:   r = s.cnt[T_A];
      IDX_B_CTL:   r = s.ctl[T_B];
      IDX_PB_CTL:  r = {s.pb_ctl[7:6], 2'h0, s.pb_ctl[3:0]};
      IDX_B_LATCH: r = s.latch[T_B];
      IDX_B_CNT:   r = s.cnt[T_B];
      IDX_D_CTL:   r = s.ctl[T_D];
      IDX_D_LATCH: r = s.latch[T_D];
      IDX_D_CNT:   r = s.cnt[T_D];
      IDX_MASK:    r = s.mask;
      IDX_FLAGS:   r = {1'b0, s.flags[6:0]}; // RQ16
      IDX_PA_EN:   r = s.pa_en;
      default:     r = RST_REG;
    endcase
    return r;
  endfunction

  // Latch registers are not evenly spaced, so each timer slot is mapped explicitly
  function automatic logic [7:0] latch_idx(input int slot);
    return (slot == T_A) ? IDX_A_LATCH : (slot == T_B) ? IDX_B_LATCH : IDX_D_LATCH;
  endfunction

  // ************************************************
  // Clock selection, edge detect and prescalers
  // ************************************************
  assign pin_edge_r = external_timer_clock_pin & ~s_q.pin_prev;
  assign pin_edge_f = ~external_timer_clock_pin & s_q.pin_prev;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tick
      logic [1:0] src;
      logic [6:0] pmask;
      assign src = s_q.ctl[gi][CTL_SRC_LO+1:CTL_SRC_LO];
      // RQ6 RQ7 reserved source code never ticks
      assign src_tick[gi] = (src == SRC_PIN) ? (s_q.ctl[gi][CTL_EDGE] ? pin_edge_f : pin_edge_r) :
                            (src == SRC_OSC) ? osc_tick :
                            (src == SRC_IRC) ? irc_tick : 1'b0;
      // RQ8 low bits of the prescaler all ones marks every 2^n-th source tick
      assign pmask = ~(PRE_ALL << s_q.ctl[gi][2:0]);
      assign cnt_tick[gi] = s_q.ctl[gi][CTL_RUN] & src_tick[gi] &
                            ((s_q.pre[gi] | ~pmask) == PRE_ALL); // RQ2
      assign ovf[gi] = cnt_tick[gi] & (s_q.cnt[gi] == CNT_TOP);
    end
  endgenerate

  // ************************************************
  // Events and interrupt decision
  // ************************************************
  assign wr_en    = s_q.ap_valid & s_q.ap_write;
  assign wd       = hwdata[7:0];
  assign pair_b   = s_q.pb_ctl[PB_PAIR];
  assign rate_hit = pair_b & ovf[T_B] & (s_q.pulses == s_q.pb_ctl[3:0]); // RQ11

  assign ev[EV_ADC]   = conversion_done; // RQ20
  assign ev[EV_PORTA] = |((port_a_pins ^ s_q.pa_prev) & s_q.pa_en); // RQ19
  assign ev[EV_D]     = ovf[T_D];
  assign ev[EV_B]     = pair_b ? rate_hit : ovf[T_B]; // RQ18
  assign ev[EV_A]     = ovf[T_A];
  assign ev[EV_FIRST] = first_timer_event;
  assign ev[EV_WIDE]  = wide_timer_event;

  assign hit = |(s_q.flags[6:0] & s_q.mask[6:0]); // RQ15 RQ22

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    s_d = s_q;
    s_d.pin_prev = external_timer_clock_pin;
    s_d.pa_prev  = port_a_pins;

    // Timers
    for (int i = 0; i < 3; i++) begin
      if (s_q.ctl[i][CTL_RUN] && src_tick[i]) begin
        s_d.pre[i] = s_q.pre[i] + 7'h01;
      end
      if (cnt_tick[i]) begin
        s_d.cnt[i] = ovf[i] ? s_q.latch[i] : s_q.cnt[i] + 8'h01; // RQ1 RQ5
      end
    end
    // RQ9 RQ23 period overflow restarts the duty timer in pair mode
    if (pair_b && ovf[T_B]) begin
      s_d.cnt[T_D] = s_q.latch[T_D];
    end

    // Pulse channel b
    if (pair_b) begin
      if (ovf[T_B]) begin
        s_d.out_b  = ~s_q.pb_ctl[PB_INIT]; // RQ10 RQ23
        s_d.pulses = rate_hit ? 4'h0 : s_q.pulses + 4'h1;
      end else if (ovf[T_D]) begin
        s_d.out_b = s_q.pb_ctl[PB_INIT]; // RQ10
      end
    end else begin
      s_d.out_b  = ~s_q.pb_ctl[PB_INIT];
      s_d.pulses = 4'h0;
    end

    // Pulse channel a, period from the first timer outside
    if (s_q.pa_ctl[PB_PAIR] && s_q.ctl[T_A][CTL_RUN]) begin // RQ2
      if (first_timer_period) begin
        s_d.out_a = ~s_q.pa_ctl[PB_INIT]; // RQ21
      end else if (ovf[T_A]) begin
        s_d.out_a = s_q.pa_ctl[PB_INIT]; // RQ21
      end
    end else begin
      s_d.out_a = ~s_q.pa_ctl[PB_INIT];
    end

    // Register writes in the data phase; a latch write with autoload set, or a D count write, beats the count step
    if (wr_en) begin
      case (s_q.ap_idx)
        IDX_PA_CTL: s_d.pa_ctl = wd;
        IDX_A_CTL:  s_d.ctl[T_A] = wd;
        IDX_B_CTL:  s_d.ctl[T_B] = wd;
        IDX_D_CTL:  s_d.ctl[T_D] = wd;
        IDX_PB_CTL: s_d.pb_ctl = wd;
        IDX_A_LATCH, IDX_B_LATCH, IDX_D_LATCH: begin
          for (int i = 0; i < 3; i++) begin
            if (s_q.ap_idx == latch_idx(i)) begin
              s_d.latch[i] = wd;
              // RQ3 RQ4 autoload is sampled at the moment of the write
              if (s_q.ctl[i][CTL_AUTOLOAD]) begin
                s_d.cnt[i] = wd;
              end
            end
          end
        end
        IDX_D_CNT:  s_d.cnt[T_D] = wd;
        IDX_PA_EN:  s_d.pa_en = wd;
        default:    s_d.pa_en = s_q.pa_en;
      endcase
    end

    // Flags: software write then hardware set, so a set wins over a clear
    s_d.flags[6:0] = ((wr_en && s_q.ap_idx == IDX_FLAGS) ? wd[6:0] : s_q.flags[6:0]) | ev; // RQ17 RQ20
    s_d.flags[7]   = 1'b0; // RQ16

    // Mask and global enable
    if (wr_en && s_q.ap_idx == IDX_MASK) begin
      s_d.mask = wd;
    end
    if (return_from_interrupt_op) begin
      s_d.mask[GIE_BIT] = 1'b1; // RQ14
    end
    // Taking an interrupt beats a simultaneous return so no request is lost
    if (s_q.mask[GIE_BIT] && hit) begin
      s_d.mask[GIE_BIT] = 1'b0; // RQ13
    end
    s_d.irq = s_q.mask[GIE_BIT] & hit; // RQ12 RQ22

    // Bus address phase; read data is fetched now and stands in the data phase
    s_d.ap_valid = hsel & htrans[1] & hready;
    if (hsel && htrans[1] && hready) begin
      s_d.ap_write = hwrite;
      s_d.ap_idx   = haddr[IDX_LSB+7:IDX_LSB];
      if (!hwrite) begin
        s_d.rdata = read_reg(haddr[IDX_LSB+7:IDX_LSB], s_q);
      end
    end
    s_d.hready = 1'b1;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      // Bus stays ready through reset so a master never stalls on it
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign hrdata          = {24'h000000, s_q.rdata};
  assign hreadyout       = s_q.hready;
  assign hresp           = 1'b0;
  assign pulse_channel_a = s_q.out_a;
  assign pulse_channel_b = s_q.out_b;
  assign irq_req         = s_q.irq;

  // ************************************************
  // Assertions
  // ************************************************
  sequence s_b_period_wrap;
    pair_b && ovf[T_B];
  endsequence

  sequence s_latch_write_auto(int i, logic [7:0] idx);
    wr_en && s_q.ap_idx == idx && s_q.ctl[i][CTL_AUTOLOAD];
  endsequence

  property p_flag7_zero;
    @(posedge clock) disable iff (sys_rst) s_q.ap_valid && !s_q.ap_write && s_q.ap_idx == IDX_FLAGS
      |-> hrdata[7] == 1'b0 && s_q.flags[7] == 1'b0;
  endproperty
  a_flag7_zero: assert property (p_flag7_zero) else $error("flag bit 7 not zero"); // RQ16

  property p_gie_clear;
    @(posedge clock) disable iff (sys_rst) s_q.mask[GIE_BIT] && hit |=> !s_q.mask[GIE_BIT] && irq_req;
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("global enable not cleared on interrupt"); // RQ13

  property p_return_from_interrupt_op;
    @(posedge clock) disable iff (sys_rst) return_from_interrupt_op && !(s_q.mask[GIE_BIT] && hit)
      |=> s_q.mask[GIE_BIT];
  endproperty
  a_return_from_interrupt_op: assert property (p_return_from_interrupt_op) else $error("return did not set global enable"); // RQ14

  property p_irq_cause;
    @(posedge clock) disable iff (sys_rst) irq_req |-> $past(s_q.mask[GIE_BIT]) && !s_q.mask[GIE_BIT];
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without global enable"); // RQ12

  property p_adc_flag;
    @(posedge clock) disable iff (sys_rst) conversion_done |=> s_q.flags[EV_ADC] [*2] or
      (s_q.flags[EV_ADC] ##1 $past(wr_en) && $past(s_q.ap_idx) == IDX_FLAGS);
  endproperty
  a_adc_flag: assert property (p_adc_flag) else $error("ADC flag lost"); // RQ20

  property p_flag_sticky;
    @(posedge clock) disable iff (sys_rst) s_q.flags[EV_D] && !(wr_en && s_q.ap_idx == IDX_FLAGS)
      |=> s_q.flags[EV_D];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("timer flag dropped by hardware"); // RQ17

  property p_wrap_reload;
    @(posedge clock) disable iff (sys_rst) ovf[T_B] && !wr_en |=> s_q.cnt[T_B] == $past(s_q.latch[T_B]);
  endproperty
  a_wrap_reload: assert property (p_wrap_reload) else $error("no reload on wrap"); // RQ5

  property p_stopped;
    @(posedge clock) disable iff (sys_rst) !s_q.ctl[T_A][CTL_RUN] && !wr_en |=> $stable(s_q.cnt[T_A]);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer moved"); // RQ2

  property p_autoload;
    @(posedge clock) disable iff (sys_rst) s_latch_write_auto(T_A, IDX_A_LATCH)
      |=> s_q.cnt[T_A] == $past(wd) && s_q.latch[T_A] == $past(wd);
  endproperty
  a_autoload: assert property (p_autoload) else $error("autoload did not copy latch"); // RQ3

  property p_period_restore;
    @(posedge clock) disable iff (sys_rst) s_b_period_wrap |=>
      pulse_channel_b == ~s_q.pb_ctl[PB_INIT] && s_q.cnt[T_D] == $past(s_q.latch[T_D]);
  endproperty
  a_period_restore: assert property (p_period_restore) else $error("period wrap did not restore"); // RQ23

  property p_rate_flag;
    @(posedge clock) disable iff (sys_rst) rate_hit |=> s_q.flags[EV_B] && s_q.pulses == 4'h0;
  endproperty
  a_rate_flag: assert property (p_rate_flag) else $error("pulse rate event missing"); // RQ11

  property p_count_step;
    @(posedge clock) disable iff (sys_rst) cnt_tick[T_B] && !ovf[T_B] && !wr_en
      |=> s_q.cnt[T_B] == $past(s_q.cnt[T_B]) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("timer did not step by one"); // RQ1

  property p_latch_only;
    @(posedge clock) disable iff (sys_rst) wr_en && s_q.ap_idx == IDX_A_LATCH && !s_q.ctl[T_A][CTL_AUTOLOAD] &&
      !cnt_tick[T_A] |=> $stable(s_q.cnt[T_A]) && s_q.latch[T_A] == $past(wd);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("plain latch write moved the count"); // RQ4

  property p_reserved_src;
    @(posedge clock) disable iff (sys_rst) s_q.ctl[T_B][CTL_SRC_LO+1:CTL_SRC_LO] == 2'h3 && !wr_en
      |=> $stable(s_q.cnt[T_B]);
  endproperty
  a_reserved_src: assert property (p_reserved_src) else $error("reserved clock source ticked"); // RQ6

  sequence s_d_pin_edge;
    s_q.ctl[T_D][CTL_RUN] && s_q.ctl[T_D][CTL_SRC_LO+1:CTL_SRC_LO] == SRC_PIN && s_q.ctl[T_D][2:0] == 3'h0 &&
      (s_q.ctl[T_D][CTL_EDGE] ? pin_edge_f : pin_edge_r);
  endsequence

  property p_edge_count;
    @(posedge clock) disable iff (sys_rst) s_d_pin_edge ##0 (!wr_en && !pair_b && s_q.cnt[T_D] != CNT_TOP)
      |=> s_q.cnt[T_D] == $past(s_q.cnt[T_D]) + 8'h01;
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("selected pin edge not counted"); // RQ7

  property p_pulse_b_idle;
    @(posedge clock) disable iff (sys_rst) !pair_b |=> pulse_channel_b == !$past(s_q.pb_ctl[PB_INIT]);
  endproperty
  a_pulse_b_idle: assert property (p_pulse_b_idle) else $error("channel b not idle outside pair mode"); // RQ9

  property p_indep_b;
    @(posedge clock) disable iff (sys_rst) !pair_b && ovf[T_B] |=> s_q.flags[EV_B];
  endproperty
  a_indep_b: assert property (p_indep_b) else $error("period timer flag missing"); // RQ18

  property p_duty_b_flip;
    @(posedge clock) disable iff (sys_rst) pair_b && ovf[T_D] && !ovf[T_B]
      |=> pulse_channel_b == $past(s_q.pb_ctl[PB_INIT]);
  endproperty
  a_duty_b_flip: assert property (p_duty_b_flip) else $error("duty overflow did not flip channel b"); // RQ10

  property p_pulse_a_drop;
    @(posedge clock) disable iff (sys_rst) s_q.pa_ctl[PB_PAIR] && ovf[T_A] && !first_timer_period
      |=> pulse_channel_a == $past(s_q.pa_ctl[PB_INIT]);
  endproperty
  a_pulse_a_drop: assert property (p_pulse_a_drop) else $error("duty overflow did not flip channel a"); // RQ21

  property p_pulse_a_idle;
    @(posedge clock) disable iff (sys_rst) !(s_q.pa_ctl[PB_PAIR] && s_q.ctl[T_A][CTL_RUN])
      |=> pulse_channel_a == !$past(s_q.pa_ctl[PB_INIT]);
  endproperty
  a_pulse_a_idle: assert property (p_pulse_a_idle) else $error("channel a not idle while stopped"); // RQ2

  property p_irq_gated;
    @(posedge clock) disable iff (sys_rst) !s_q.mask[GIE_BIT] |=> !irq_req;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("request while global enable off"); // RQ12

  property p_port_flag;
    @(posedge clock) disable iff (sys_rst) |((port_a_pins ^ s_q.pa_prev) & s_q.pa_en) |=> s_q.flags[EV_PORTA];
  endproperty
  a_port_flag: assert property (p_port_flag) else $error("port change flag missing"); // RQ19

endmodule
`default_nettype wire

//--- verif/tpiu_tb_top.sv
// Self-checking testbench for the timer, pulse and interrupt unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tpiu_tb_top import tpiu_pkg::*; ;
  logic        clock = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, exp_v;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        ext_pin = 1'b0, osc_tick = 1'b0, irc_tick = 1'b0, conv_done = 1'b0;
  logic        first_ev = 1'b0, wide_ev = 1'b0, rfi = 1'b0, first_per = 1'b0;
  logic [7:0]  pa_pins = 8'h00, lf = 8'h1E, v;
  logic        hreadyout, hresp, out_a, out_b, irq_req, rd_pend = 1'b0;
  logic [31:0] rdq[$];
  int          fail_count = 0, n_compared = 0, irq_n = 0, ni = 0;
  logic [7:0]  ri [10] = '{IDX_A_CTL, IDX_A_LATCH, IDX_B_CTL, IDX_PB_CTL, IDX_B_LATCH, IDX_D_CTL,
                           IDX_D_LATCH, IDX_D_CNT, IDX_MASK, IDX_PA_EN};
  logic [7:0]  rm [10] = '{8'h7F, 8'hFF, 8'h7F, 8'h4F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'hFF};
  logic [7:0]  sc [6]  = '{8'hC0, 8'hC8, 8'hD0, 8'hE0, 8'hF0, 8'h60};
  logic [7:0]  se [6]  = '{8'h05, 8'h04, 8'h03, 8'h07, 8'h00, 8'h00};
  logic [7:0]  evb [4] = '{8'h40, 8'h20, 8'h02, 8'h01};
  logic [3:0]  rr [2]  = '{4'h3, 4'hF};

  tpiu_top tpiu_top_i (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_timer_clock_pin(ext_pin), .osc_tick(osc_tick), .irc_tick(irc_tick),
    .first_timer_period(first_per), .first_timer_event(first_ev), .wide_timer_event(wide_ev),
    .conversion_done(conv_done), .port_a_pins(pa_pins), .return_from_interrupt_op(rfi),
    .pulse_channel_a(out_a), .pulse_channel_b(out_b), .irq_req(irq_req)
  );

  initial begin
    forever #2 clock = ~clock;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // ************************************************
  // Bus master and read-data monitor
  // ************************************************
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Bounded wait for hready; running out counts as a mismatch
  task automatic wrdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // Trailing idle cycle so a following read sees the written value
  task automatic bus(input logic wr_n, input logic [7:0] idx, input logic [7:0] wd, input logic [7:0] ex);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr_n;
    wrdy();
    if (!wr_n) rdq.push_back({24'h0, ex});
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wrdy();
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 8'h00);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
    bus(1'b0, idx, 8'h00, ex);
  endtask

  // Ticks of the oscillator (o=1) or internal RC (o=0), one per cycle
  task automatic tks(input int n, input logic o);
    repeat (n) begin
      osc_tick <= o;
      irc_tick <= !o;
      @(posedge clock);
    end
    osc_tick <= 1'b0;
    irc_tick <= 1'b0;
    cyc(3);
  endtask

  task automatic ev(input int k);
    case (k)
      0: conv_done <= 1'b1;
      1: pa_pins <= pa_pins ^ 8'h01;
      2: first_ev <= 1'b1;
      default: wide_ev <= 1'b1;
    endcase
    @(posedge clock);
    conv_done <= 1'b0;
    first_ev <= 1'b0;
    wide_ev <= 1'b0;
    cyc(4);
  endtask

  always @(posedge clock) begin
    if (rd_pend && hreadyout === 1'b1) begin
      exp_v = rdq.pop_front();
      `CHK(hrdata, exp_v)
      `CHK(hresp, 1'b0)
    end
    if (hreadyout === 1'b1) rd_pend = hsel && htrans[1] && !hwrite;
  end

  always @(posedge clock) begin
    if (irq_req === 1'b1) irq_n++;
  end

  // ************************************************
  // Scenarios
  // ************************************************
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(2);
    `CHK(out_a, 1'b1)
    `CHK(out_b, 1'b1)
    for (int k = 0; k < 10; k++) rd(ri[k], 8'h00);
    rd(IDX_A_CNT, 8'h00);
    rd(IDX_B_CNT, 8'h00);
    rd(IDX_FLAGS, 8'h00);
    for (int k = 0; k < 10; k++) begin
      lf = lfsr(lf);
      v = lf & rm[k];
      wr(ri[k], v);
      rd(ri[k], v);
    end
    wr(8'h30, 8'hA5);
    rd(8'h30, 8'h00);
    for (int k = 0; k < 10; k++) wr(ri[k], 8'h00);
    wr(IDX_FLAGS, 8'hFF);
    rd(IDX_FLAGS, 8'h7F);
    wr(IDX_FLAGS, 8'h00);
    $display("test registers done");
    wr(IDX_A_LATCH, 8'h55);
    rd(IDX_A_CNT, 8'h00);
    wr(IDX_A_CTL, 8'h40);
    rd(IDX_A_CNT, 8'h00);
    wr(IDX_A_LATCH, 8'h66);
    rd(IDX_A_CNT, 8'h66);
    for (int p = 0; p < 8; p++) begin
      wr(IDX_A_LATCH, 8'h00);
      wr(IDX_A_CTL, 8'hD0 | 8'(p));
      tks(256, 1'b1);
      wr(IDX_A_CTL, 8'h40);
      rd(IDX_A_CNT, 8'(256 >> p));
    end
    rd(IDX_FLAGS, 8'h04);
    wr(IDX_FLAGS, 8'h00);
    $display("test autoload and prescaler done");
    wr(IDX_D_CTL, 8'h40);
    for (int k = 0; k < 6; k++) begin
      wr(IDX_D_LATCH, 8'h00);
      wr(IDX_D_CTL, sc[k]);
      for (int j = 0; j < 9; j++) begin
        ext_pin <= ~j[0];
        osc_tick <= (j < 3);
        irc_tick <= (j < 7);
        @(posedge clock);
      end
      osc_tick <= 1'b0;
      irc_tick <= 1'b0;
      cyc(2);
      wr(IDX_D_CTL, 8'h40);
      ext_pin <= 1'b0;
      rd(IDX_D_CNT, se[k]);
    end
    $display("test clock sources done");
    wr(IDX_B_CTL, 8'h40);
    wr(IDX_B_LATCH, 8'hFC);
    wr(IDX_B_CTL, 8'hE0);
    tks(6, 1'b0);
    wr(IDX_B_CTL, 8'h40);
    rd(IDX_B_CNT, 8'hFE);
    rd(IDX_FLAGS, 8'h08);
    rd(IDX_FLAGS, 8'h08);
    wr(IDX_FLAGS, 8'h00);
    $display("test wrap reload done");
    wr(IDX_B_LATCH, 8'hFC);
    wr(IDX_D_LATCH, 8'hFD);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_PB_CTL, 8'(i << 6));
      cyc(1);
      `CHK(out_b, ~1'(i))
      wr(IDX_PB_CTL, 8'h80 | 8'(i << 6));
      wr(IDX_D_CTL, 8'hE0);
      wr(IDX_B_CTL, 8'hE0);
      for (int t = 1; t < 9; t++) begin
        tks(1, 1'b0);
        `CHK(out_b, (t % 4 == 3) ? 1'(i) : ~1'(i))
      end
      rd(IDX_FLAGS, 8'h18);
      wr(IDX_FLAGS, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      wr(IDX_PB_CTL, {4'h8, rr[k]});
      tks(4 * int'(rr[k]) + 3, 1'b0);
      rd(IDX_FLAGS, 8'h10);
      tks(1, 1'b0);
      rd(IDX_FLAGS, 8'h18);
      wr(IDX_FLAGS, 8'h00);
    end
    wr(IDX_B_CTL, 8'h00);
    wr(IDX_D_CTL, 8'h00);
    wr(IDX_PB_CTL, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_PA_CTL, 8'h80 | 8'(i << 6));
      rd(IDX_PA_CTL, 8'h80 | 8'(i << 6));
      wr(IDX_A_LATCH, 8'hFE);
      wr(IDX_A_CTL, 8'hE0);
      `CHK(out_a, ~1'(i))
      tks(2, 1'b0);
      `CHK(out_a, 1'(i))
      first_per <= 1'b1;
      @(posedge clock);
      first_per <= 1'b0;
      cyc(2);
      `CHK(out_a, ~1'(i))
      tks(2, 1'b0);
      `CHK(out_a, 1'(i))
      wr(IDX_A_CTL, 8'h40);
      cyc(1);
      `CHK(out_a, ~1'(i))
    end
    wr(IDX_PA_CTL, 8'h00);
    wr(IDX_FLAGS, 8'h00);
    $display("test pulse channel done");
    wr(IDX_PA_EN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_MASK, 8'h80);
      ev(k);
      `CHK(irq_n, ni)
      rd(IDX_FLAGS, evb[k]);
      wr(IDX_FLAGS, 8'h00);
      wr(IDX_MASK, 8'h80 | evb[k]);
      ev(k);
      ni++;
      `CHK(irq_n, ni)
      rd(IDX_MASK, evb[k]);
      ev(k);
      `CHK(irq_n, ni)
      wr(IDX_FLAGS, 8'h00);
      rfi <= 1'b1;
      @(posedge clock);
      rfi <= 1'b0;
      cyc(3);
      rd(IDX_MASK, 8'h80 | evb[k]);
      `CHK(irq_n, ni)
      wr(IDX_MASK, 8'h00);
    end
    $display("test interrupts done");
    end_of_test();
  end
endmodule
`default_nettype wire
